// [fpad_top.v]
/*
 Flash program address, data and row source logic with the operation
 sequencer. Software reaches registers over a plain strobe port. Row data
 is fetched from system memory as bus master, buffered in a FIFO and
 written to the flash array. Assumes the flash array answers each
 command with a one-cycle done pulse and the system bus answers each
 read with a one-cycle valid pulse.
*/
// Operation
// RULE_01: A whole-array erase ignores the flash target address entirely.
// RULE_02: A page erase erases the page chosen by the target address.
// RULE_03: A row program writes the row chosen by the target address.
// RULE_04: A word program writes the word chosen by the target address.
// RULE_05: The target address is a 32-bit read/write register, zero at power-on.
// RULE_06: The program word data is a 32-bit read/write register.
// RULE_07: The program word data is cleared only by power-on reset.
// RULE_08: The row source address is a 32-bit read/write register, zero at power-on.
// RULE_09: Row programming takes its data from memory at the row source address.
// RULE_10: Codes 1, 3, 4, 5 are word, row, page and array; protected or other codes do nothing.
// RULE_11: The trigger bit starts the operation and hardware clears it on completion.
// RULE_12: The trigger accepts writes only while armed and after the unlock sequence.
// RULE_13: Row programming fetches consecutive words as bus master before writing them.
`timescale 1ns/1ps
`include "fpad_consts.vh"
module fpad_top (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        por_rst,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        region_protected,
    output reg         flash_cmd_valid,
    output reg  [3:0]  flash_cmd_op,
    output reg  [31:0] flash_cmd_addr,
    output reg  [31:0] flash_cmd_data,
    input  wire        flash_cmd_done,
    input  wire        flash_cmd_fail,
    output reg         bus_rd_req,
    output reg  [31:0] bus_rd_addr,
    input  wire        bus_rd_valid,
    input  wire [31:0] bus_rd_data
);
    localparam ST_IDLE  = 3'd0;
    localparam ST_FETCH = 3'd1;
    localparam ST_WAIT  = 3'd2;
    localparam ST_ISSUE = 3'd3;
    localparam ST_BUSY  = 3'd4;
    localparam ST_DONE  = 3'd5;

    reg [31:0] flash_target_address;
    reg [31:0] program_word_data;
    reg [31:0] row_source_address;
    reg [3:0]  operation_code;
    reg        write_arm;
    reg        trigger;
    reg        write_error;
    reg [1:0]  unlock_stage;
    reg [2:0]  state;
    reg [7:0]  fetched;
    reg [7:0]  written;
    reg        protect_s1;
    reg        protect_s2;
    wire       fifo_in_ready;
    wire [31:0] fifo_out_data;
    wire       fifo_out_valid;
    reg        fifo_pop;
    reg        row_mode;

    // Decodes whether the code names a real operation.
    function is_valid_op;
        input [3:0] op;
        begin
            is_valid_op = (op == `FPAD_OP_WORD) || (op == `FPAD_OP_ROW) ||
                          (op == `FPAD_OP_PAGE) || (op == `FPAD_OP_ARRAY);
        end
    endfunction

    fpad_fifo #(
        .WIDTH (32),
        .DEPTH (`FPAD_FIFO_DEPTH),
        .ABITS (`FPAD_FIFO_ABITS)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_data   (bus_rd_data),
        .in_valid  (bus_rd_valid),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    // Protection comes from option logic outside this clock's control.
    always @(posedge mclk) begin
        protect_s1 <= region_protected;
        protect_s2 <= protect_s1;
    end

    // The data word survives device resets, so only power-on clears it.
    always @(posedge mclk) begin
        if (por_rst) begin
            program_word_data <= `FPAD_RST_WORD; // see RULE_07
        end else if (reg_wr && reg_addr == `FPAD_OFF_DATA) begin
            program_word_data <= reg_wdata; // see RULE_06
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            flash_target_address <= `FPAD_RST_WORD; // see RULE_05
            row_source_address   <= `FPAD_RST_WORD; // see RULE_08
            operation_code  <= 4'h0;
            write_arm       <= 1'b0;
            trigger         <= 1'b0;
            write_error     <= 1'b0;
            unlock_stage    <= 2'd0;
            state           <= ST_IDLE;
            fetched         <= 8'h00;
            written         <= 8'h00;
            row_mode        <= 1'b0;
            flash_cmd_valid <= 1'b0;
            flash_cmd_op    <= 4'h0;
            flash_cmd_addr  <= `FPAD_RST_WORD;
            flash_cmd_data  <= `FPAD_RST_WORD;
            bus_rd_req      <= 1'b0;
            bus_rd_addr     <= `FPAD_RST_WORD;
        end else begin
            flash_cmd_valid <= 1'b0;
            bus_rd_req      <= 1'b0;
            if (reg_wr) begin
                if (reg_addr == `FPAD_OFF_TARGET) begin
                    flash_target_address <= reg_wdata; // see RULE_05
                end
                if (reg_addr == `FPAD_OFF_SOURCE) begin
                    row_source_address <= reg_wdata; // see RULE_08
                end
                if (reg_addr == `FPAD_OFF_KEY) begin
                    if (reg_wdata == `FPAD_KEY_FIRST) begin
                        unlock_stage <= 2'd1;
                    end else if (reg_wdata == `FPAD_KEY_SECOND &&
                                 unlock_stage == 2'd1) begin
                        unlock_stage <= 2'd2;
                    end else begin
                        unlock_stage <= 2'd0;
                    end
                end else if (reg_addr == `FPAD_OFF_CONTROL) begin
                    // The unlock is spent by any control write.
                    unlock_stage <= 2'd0;
                    if (!trigger) begin
                        write_arm <= reg_wdata[`FPAD_CTL_ARM];
                        if (!write_arm) begin
                            operation_code <= reg_wdata[3:0];
                        end
                    end
                    if (reg_wdata[`FPAD_CTL_TRIGGER] && write_arm &&
                        unlock_stage == 2'd2 && !trigger) begin
                        trigger     <= 1'b1; // see RULE_12
                        write_error <= 1'b0;
                    end
                end
            end
            case (state)
                ST_IDLE: begin
                    if (trigger) begin
                        fetched  <= 8'h00;
                        written  <= 8'h00;
                        row_mode <= (operation_code == `FPAD_OP_ROW);
                        if (!is_valid_op(operation_code) || protect_s2) begin
                            state <= ST_DONE; // see RULE_10
                        end else if (operation_code == `FPAD_OP_ROW) begin
                            state <= ST_FETCH; // see RULE_09
                        end else begin
                            state <= ST_ISSUE;
                        end
                    end
                end
                ST_FETCH: begin
                    // One outstanding read at a time keeps the FIFO honest.
                    if (fetched == `FPAD_ROW_WORDS) begin
                        state <= ST_ISSUE;
                    end else if (fifo_in_ready) begin
                        bus_rd_req  <= 1'b1; // see RULE_13
                        bus_rd_addr <= row_source_address +
                                       {22'd0, fetched, 2'b00}; // see RULE_09
                        state       <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (bus_rd_valid) begin
                        fetched <= fetched + 8'h01;
                        state   <= ST_FETCH;
                    end
                end
                ST_ISSUE: begin
                    if (!row_mode || fifo_out_valid) begin
                        flash_cmd_valid <= 1'b1;
                        flash_cmd_op    <= operation_code; // see RULE_10
                        if (operation_code == `FPAD_OP_ARRAY) begin
                            flash_cmd_addr <= `FPAD_RST_WORD; // see RULE_01
                        end else if (row_mode) begin
                            flash_cmd_addr <= flash_target_address +
                                {22'd0, written, 2'b00}; // see RULE_03
                        end else begin
                            flash_cmd_addr <= flash_target_address; // see RULE_02, RULE_04
                        end
                        flash_cmd_data  <= row_mode ? fifo_out_data
                                                    : program_word_data;
                        state <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (flash_cmd_done) begin
                        if (flash_cmd_fail) begin
                            write_error <= 1'b1;
                        end
                        if (row_mode &&
                            written != `FPAD_ROW_WORDS - 8'h01 &&
                            !flash_cmd_fail) begin
                            written <= written + 8'h01;
                            state   <= ST_ISSUE; // see RULE_03
                        end else begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // An aborted row leaves words that must not leak on.
                    if (!fifo_out_valid) begin
                        trigger <= 1'b0; // see RULE_11
                        state   <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always @* begin
        fifo_pop = 1'b0;
        if (state == ST_BUSY && row_mode && flash_cmd_done) begin
            fifo_pop = 1'b1;
        end else if (state == ST_DONE) begin
            fifo_pop = 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= `FPAD_RST_WORD;
        end else if (reg_rd) begin
            case (reg_addr)
                `FPAD_OFF_TARGET:  reg_rdata <= flash_target_address;
                `FPAD_OFF_DATA:    reg_rdata <= program_word_data;
                `FPAD_OFF_SOURCE:  reg_rdata <= row_source_address;
                `FPAD_OFF_CONTROL: reg_rdata <= {16'h0000, trigger, write_arm,
                                                 write_error, 9'h000,
                                                 operation_code};
                default:           reg_rdata <= `FPAD_RST_WORD;
            endcase
        end else begin
            reg_rdata <= `FPAD_RST_WORD;
        end
    end
endmodule

// [fpad_consts.vh]
/*
 Constants for the flash program address and data block: register
 offsets, operation codes, field positions and reset values.
 Assumes it is included by its bare name from the design files.
*/
`ifndef FPAD_CONSTS_VH
`define FPAD_CONSTS_VH
`define FPAD_OFF_TARGET   8'h00
`define FPAD_OFF_DATA     8'h04
`define FPAD_OFF_SOURCE   8'h08
`define FPAD_OFF_CONTROL  8'h0C
`define FPAD_OFF_KEY      8'h10
`define FPAD_RST_WORD     32'h0000_0000
`define FPAD_OP_WORD      4'h1
`define FPAD_OP_ROW       4'h3
`define FPAD_OP_PAGE      4'h4
`define FPAD_OP_ARRAY     4'h5
`define FPAD_CTL_TRIGGER  15
`define FPAD_CTL_ARM      14
`define FPAD_CTL_ERROR    13
`define FPAD_KEY_FIRST    32'hAA99_6655
`define FPAD_KEY_SECOND   32'h5566_99AA
`define FPAD_ROW_WORDS    8'h10
`define FPAD_FIFO_DEPTH   16
`define FPAD_FIFO_ABITS   4
`endif

// [fpad_fifo.v]
/*
 Synchronous FIFO with valid and ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module fpad_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter ABITS = 4
) (
    input  wire             mclk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [ABITS-1:0] wr_ptr;
    reg [ABITS-1:0] rd_ptr;
    reg [ABITS:0]   count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[ABITS:0]);
    assign out_valid = (count != {(ABITS+1){1'b0}});
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
        if (sys_rst) begin
            wr_ptr <= {ABITS{1'b0}};
            rd_ptr <= {ABITS{1'b0}};
            count  <= {(ABITS+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// [fpad_top_props.sv]
/* Checker for fpad_top: register port answers and far-side handshakes.
   Assumes it is bound to fpad_top and sees only its ports. */
`timescale 1ns/1ps
`include "fpad_consts.vh"
module fpad_checker (
    input wire        mclk,
    input wire        sys_rst,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_rdata,
    input wire        flash_cmd_valid,
    input wire [3:0]  flash_cmd_op,
    input wire [31:0] flash_cmd_addr,
    input wire        bus_rd_req,
    input wire        bus_rd_valid
);
    reg [1:0] outst;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Counts bus reads in flight so a second request can be caught.
    always @(posedge mclk) begin
        if (sys_rst)
            outst <= 2'd0;
        else
            outst <= outst + {1'b0, bus_rd_req} - {1'b0, bus_rd_valid};
    end
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 0)
        else $error("read data not zero outside an answer");
    regs_rw_a: assert property ($past(reg_wr) && reg_rd &&
        reg_addr == $past(reg_addr) && reg_addr < 8'h0C && reg_addr[1:0] == 2'b00
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("read back differs");
    key_read_a: assert property (reg_rd && reg_addr == `FPAD_OFF_KEY
        |=> reg_rdata == 0) else $error("unlock register readable");
    cmd_pulse_a: assert property (flash_cmd_valid |=> !flash_cmd_valid)
        else $error("flash command longer than one cycle");
    cmd_hold_a: assert property (!flash_cmd_valid && !$past(sys_rst)
        |-> $stable(flash_cmd_addr) && $stable(flash_cmd_op))
        else $error("flash command fields moved");
    array_addr_a: assert property (flash_cmd_valid &&
        flash_cmd_op == `FPAD_OP_ARRAY |-> flash_cmd_addr == 0)
        else $error("array erase carries an address");
    req_pulse_a: assert property (bus_rd_req |=> !bus_rd_req)
        else $error("bus request longer than one cycle");
    bus_single_a: assert property (bus_rd_req |-> outst == 2'd0)
        else $error("second bus read while one outstanding");
    cover property (flash_cmd_valid && flash_cmd_op == `FPAD_OP_WORD);
    cover property (flash_cmd_valid && flash_cmd_op == `FPAD_OP_ARRAY);
    cover property (bus_rd_req ##[1:20] bus_rd_req);
endmodule

// [fpad_far_model.sv]
/* Far side: flash array answering commands and system bus answering reads.
   Assumes one request outstanding per side; the fast/slow choice toggles on each bus read. */
`timescale 1ns/1ps
module fpad_far_model (
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        flash_cmd_valid,
    input  wire        bus_rd_req,
    input  wire [31:0] bus_rd_addr,
    output reg         flash_cmd_done,
    output wire        flash_cmd_fail,
    output reg         bus_rd_valid,
    output reg  [31:0] bus_rd_data
);
    reg [3:0]  fl_wait;
    reg [3:0]  bs_wait;
    reg [31:0] bs_addr;
    reg        slow;
    assign flash_cmd_fail = 1'b0;
    always @(posedge mclk) begin
        flash_cmd_done <= 1'b0;
        bus_rd_valid   <= 1'b0;
        // Released data lines toggle so stale words are never mistaken.
        bus_rd_data    <= ~bus_rd_data;
        if (sys_rst) begin
            fl_wait     <= 4'h0;
            bs_wait     <= 4'h0;
            slow        <= 1'b0;
            bus_rd_data <= 32'h0000_0000;
        end else begin
            if (flash_cmd_valid)
                fl_wait <= slow ? 4'h6 : 4'h1;
            else if (fl_wait == 4'h1)
                flash_cmd_done <= 1'b1;
            if (!flash_cmd_valid && fl_wait != 4'h0)
                fl_wait <= fl_wait - 4'h1;
            if (bus_rd_req) begin
                bs_wait <= slow ? 4'h5 : 4'h1;
                bs_addr <= bus_rd_addr;
                slow    <= ~slow;
            end else if (bs_wait == 4'h1) begin
                bus_rd_valid <= 1'b1;
                bus_rd_data  <= bs_addr ^ 32'h5A5A_5A5A;
            end
            if (!bus_rd_req && bs_wait != 4'h0)
                bs_wait <= bs_wait - 4'h1;
        end
    end
endmodule

// [fpad_top_tb_top.sv]
/* Bench for fpad_top: register tasks, operations, refusals and resets.
   Assumes the far-side model and checker are compiled before it. */
`timescale 1ns/1ps
`include "fpad_consts.vh"
`define fpad_check(nm, exp, got) begin checks_done = checks_done + 1; \
    if ((got) !== (exp)) begin err_count = err_count + 1; \
    $display("wrong value %s exp %h got %h", nm, exp, got); end end
module fpad_top_tb_top;
    reg         mclk, sys_rst, por_rst, reg_wr, reg_rd, region_protected;
    reg  [7:0]  reg_addr;
    reg  [31:0] reg_wdata, seen;
    reg  [3:0]  op;
    reg  [31:0] req_addr [0:15];
    wire [31:0] reg_rdata, flash_cmd_addr, flash_cmd_data;
    wire [31:0] bus_rd_addr, bus_rd_data;
    wire [3:0]  flash_cmd_op;
    wire        flash_cmd_valid, flash_cmd_done, flash_cmd_fail;
    wire        bus_rd_req, bus_rd_valid;
    integer     err_count, checks_done, cmds, reqs, k;
    fpad_top fpad_top_i (.mclk(mclk), .sys_rst(sys_rst), .por_rst(por_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .region_protected(region_protected),
        .flash_cmd_valid(flash_cmd_valid), .flash_cmd_op(flash_cmd_op),
        .flash_cmd_addr(flash_cmd_addr), .flash_cmd_data(flash_cmd_data),
        .flash_cmd_done(flash_cmd_done), .flash_cmd_fail(flash_cmd_fail),
        .bus_rd_req(bus_rd_req), .bus_rd_addr(bus_rd_addr),
        .bus_rd_valid(bus_rd_valid), .bus_rd_data(bus_rd_data));
    fpad_far_model fpad_far_model_i (.mclk(mclk), .sys_rst(sys_rst),
        .flash_cmd_valid(flash_cmd_valid), .bus_rd_req(bus_rd_req),
        .bus_rd_addr(bus_rd_addr), .flash_cmd_done(flash_cmd_done),
        .flash_cmd_fail(flash_cmd_fail), .bus_rd_valid(bus_rd_valid),
        .bus_rd_data(bus_rd_data));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (flash_cmd_valid)
            cmds = cmds + 1;
        if (bus_rd_req && reqs < 16)
            req_addr[reqs] = bus_rd_addr;
        if (bus_rd_req)
            reqs = reqs + 1;
    end
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            reg_wr <= 1'b1;
            reg_rd <= 1'b0;
            reg_addr <= a;
            reg_wdata <= d;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge mclk);
            reg_rd <= 1'b1;
            reg_wr <= 1'b0;
            reg_addr <= a;
            @(posedge mclk);
            reg_rd <= 1'b0;
            @(negedge mclk);
            seen = reg_rdata;
        end
    endtask
    task idle(input integer n);
        begin
            repeat (n) begin
                @(posedge mclk);
                reg_wr <= 1'b0;
                reg_rd <= 1'b0;
            end
        end
    endtask
    // Arm is cleared first because the code only lands while unarmed.
    task run_op(input [3:0] code, input keys);
        integer n;
        begin
            wr(`FPAD_OFF_CONTROL, 32'h0000_0000);
            wr(`FPAD_OFF_CONTROL, 32'h0000_4000 | code);
            if (keys) begin
                wr(`FPAD_OFF_KEY, `FPAD_KEY_FIRST);
                wr(`FPAD_OFF_KEY, `FPAD_KEY_SECOND);
            end
            wr(`FPAD_OFF_CONTROL, 32'h0000_C000 | code);
            idle(1);
            for (n = 0; n < 300; n = n + 1) begin
                rd(`FPAD_OFF_CONTROL);
                if (seen[15] === 1'b0)
                    n = 300;
            end
            `fpad_check("trigger", 1'b0, seen[15])
        end
    endtask
    task pulse_rst(input por);
        begin
            idle(1);
            @(posedge mclk);
            sys_rst <= 1'b1;
            por_rst <= por;
            @(posedge mclk);
            sys_rst <= 1'b0;
            por_rst <= 1'b0;
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        err_count = err_count + 1;
        report_and_stop;
    end
    initial begin
        {sys_rst, por_rst, reg_wr, reg_rd, region_protected} = 5'b11000;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        {err_count, checks_done, cmds, reqs} = 0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        for (op = 0; op < 3; op = op + 1) begin
            rd({4'h0, op, 2'b00});
            `fpad_check("reset value", 32'h0, seen)
            wr({4'h0, op, 2'b00}, 32'hF0E1_D2C3 ^ op);
            rd({4'h0, op, 2'b00});
            `fpad_check("read back", 32'hF0E1_D2C3 ^ op, seen)
        end
        rd(8'h20);
        `fpad_check("unmapped", 32'h0, seen)
        rd(`FPAD_OFF_KEY);
        `fpad_check("key read", 32'h0, seen)
        wr(`FPAD_OFF_TARGET, 32'h0000_1234);
        wr(`FPAD_OFF_DATA, 32'hDEAD_BEEF);
        for (k = 0; k < 3; k = k + 1) begin
            op = k == 0 ? `FPAD_OP_WORD : k == 1 ? `FPAD_OP_PAGE : `FPAD_OP_ARRAY;
            run_op(op, 1'b1);
            `fpad_check("op", op, flash_cmd_op)
            `fpad_check("addr", op == 5 ? 0 : 32'h1234, flash_cmd_addr)
            `fpad_check("cmds", op == 1 ? 1 : op - 2, cmds)
        end
        `fpad_check("data", 32'hDEAD_BEEF, flash_cmd_data)
        run_op(4'h6, 1'b1);
        `fpad_check("no-op code", 3, cmds)
        @(posedge mclk);
        region_protected <= 1'b1;
        idle(3);
        run_op(`FPAD_OP_WORD, 1'b1);
        `fpad_check("protected", 3, cmds)
        @(posedge mclk);
        region_protected <= 1'b0;
        run_op(`FPAD_OP_WORD, 1'b0);
        `fpad_check("locked", 3, cmds)
        wr(`FPAD_OFF_DATA, 32'h1357_9BDF);
        pulse_rst(1'b0);
        rd(`FPAD_OFF_DATA);
        `fpad_check("data kept", 32'h1357_9BDF, seen)
        rd(`FPAD_OFF_TARGET);
        `fpad_check("target cleared", 32'h0, seen)
        pulse_rst(1'b1);
        rd(`FPAD_OFF_DATA);
        `fpad_check("data cleared", 32'h0, seen)
        wr(`FPAD_OFF_SOURCE, 32'h0000_2000);
        reqs = 0;
        run_op(`FPAD_OP_ROW, 1'b1);
        for (k = 0; k < 400 && reqs < 16; k = k + 1)
            @(posedge mclk);
        for (k = 0; k < 16; k = k + 1)
            `fpad_check("row source", 32'h2000 + 4 * k, req_addr[k])
        `fpad_check("row cmds", 19, cmds)
        `fpad_check("row op", `FPAD_OP_ROW, flash_cmd_op)
        `fpad_check("row addr", 32'h0000_003C, flash_cmd_addr)
        `fpad_check("row data", 32'h5A5A_7A66, flash_cmd_data)
        // A late device reset must leave the idle block quiet.
        pulse_rst(1'b0);
        idle(2);
        report_and_stop;
    end
endmodule
bind fpad_top fpad_checker fpad_checker_i (.mclk(mclk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_cmd_valid(flash_cmd_valid), .flash_cmd_op(flash_cmd_op),
    .flash_cmd_addr(flash_cmd_addr), .bus_rd_req(bus_rd_req),
    .bus_rd_valid(bus_rd_valid));
